//--- hdl/tcdo_pkg.sv
// Package: constants and carrier types of the two-channel output port
package tcdo_pkg;

  // ------------------------------------------------------------------
  // Channel and synchroniser shape
  // ------------------------------------------------------------------
  localparam int          CH_COUNT      = 2;
  localparam int          SYNC_STAGES   = 3;
  localparam int          STAT_COUNT    = 3 + 3 * CH_COUNT;

  // ------------------------------------------------------------------
  // Output image: offset, used bits, value after reset
  // ------------------------------------------------------------------
  localparam logic [7:0]  OFS_IMAGE     = 8'h00;
  localparam logic [7:0]  IMAGE_USED    = 8'h03;
  localparam logic [7:0]  IMAGE_RST     = 8'h00;

  // ------------------------------------------------------------------
  // Object access: CANopen index, EtherCAT base and subindices
  // ------------------------------------------------------------------
  localparam logic [15:0] CO_IDX_IMAGE  = 16'h5200;
  localparam logic [7:0]  CO_SUB_IMAGE  = 8'h00;
  localparam logic [15:0] ECAT_IDX_BASE = 16'h7000;
  localparam logic [7:0]  ECAT_SUB_CH0  = 8'h01;
  localparam logic [7:0]  ECAT_SUB_CH1  = 8'h02;

  // ------------------------------------------------------------------
  // Data sizes reported to the head station
  // ------------------------------------------------------------------
  localparam logic [7:0]  IN_BYTES      = 8'h00;
  localparam logic [7:0]  OUT_BYTES     = 8'h01;
  localparam logic [7:0]  PRM_BYTES     = 8'h00;
  localparam logic [7:0]  DIAG_BYTES    = 8'h00;

  // ------------------------------------------------------------------
  // Timing: clock rate and fault LED blink rate
  // ------------------------------------------------------------------
  localparam longint      CLK_HZ        = 250_000_000;
  localparam longint      BLINK_HZ      = 2;
  localparam int          BLINK_HALF_CYC = int'(CLK_HZ / (2 * BLINK_HZ));

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    LED_DARK     = 3'b000,
    LED_RUN      = 3'b001,
    LED_RUN_FLT  = 3'b010,
    LED_FLT_ONLY = 3'b011,
    LED_CFG      = 3'b100
  } tcdo_led_mode_t;

  typedef enum logic {
    OBJ_CANOPEN  = 1'b0,
    OBJ_ETHERCAT = 1'b1
  } tcdo_obj_kind_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } tcdo_img_wr_t;

  typedef struct packed {
    tcdo_obj_kind_t kind;
    logic [15:0]    index;
    logic [7:0]     subidx;
    logic [7:0]     data;
  } tcdo_obj_wr_t;

  typedef struct packed {
    logic in_rd;
    logic prm_wr;
    logic diag_rd;
  } tcdo_svc_req_t;

  typedef struct packed {
    logic [7:0] in_bytes;
    logic [7:0] out_bytes;
    logic [7:0] prm_bytes;
    logic [7:0] diag_bytes;
  } tcdo_sizes_t;

endpackage

//--- hdl/tcdo_blink.sv
// Square-wave blinker for the fault LED
`timescale 1ns/10ps
module tcdo_blink #(
  parameter int HALF_CYC = tcdo_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Control and output
  input  wire logic en,
  output logic      blink_q
);
  import tcdo_pkg::*;

  localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          blink_d;

  // Next count; restart lit so a fresh fault shows at once
  always_comb begin
    cnt_d   = cnt_q;
    blink_d = blink_q;
    if (!en) begin
      cnt_d   = '0;
      blink_d = 1'b1;
    end else if (cnt_q == LAST) begin
      cnt_d   = '0;
      blink_d = ~blink_q;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // Register the blinker
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q   <= '0;
      blink_q <= 1'b1;
    end else begin
      cnt_q   <= cnt_d;
      blink_q <= blink_d;
    end
  end

endmodule

//--- hdl/tcdo_port.sv
// Two-channel digital output port: image, object access, status LEDs
//
// Function
// [RL1] Output image byte at offset zero; bit 0 and 1 drive channels; CANopen 5200h.
// [RL2] EtherCAT reaches each output bit at index 7000h plus slot, subindex 01h/02h.
// [RL3] No input area bytes are used; input reads return no data.
// [RL4] Communication fine, no fault: run LED steady, fault LED dark.
// [RL5] Communication fine with driver fault: run and fault LEDs both steady.
// [RL6] No communication with driver fault: run LED dark, fault LED steady.
// [RL7] Bus supply failed: run LED and fault LED both dark.
// [RL8] Configuration error blinks fault LED at 2 Hz regardless of others; here a bus supply loss still keeps it dark.
// [RL9] In normal running each channel LED follows its output bit.
// [RL10] No interrupts, no diagnostic readout, no parameter bytes accepted.
// [RL11] Reserved image bits ignored; driver faults merge into one error flag.
`timescale 1ns/10ps
module tcdo_port #(
  parameter int BLINK_HALF = tcdo_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  // Process image write from the backplane logic
  input  wire logic                  img_wr,
  input  wire tcdo_pkg::tcdo_img_wr_t img_req,
  output logic                       img_ack,
  // Object dictionary write (CANopen or EtherCAT coupler)
  input  wire logic                  obj_wr,
  input  wire tcdo_pkg::tcdo_obj_wr_t obj_req,
  input  wire logic [7:0]            slot_num,
  output logic                       obj_ack,
  output logic                       obj_nak,
  // Service requests the module refuses
  input  wire tcdo_pkg::tcdo_svc_req_t svc_req,
  output logic                       svc_nak,
  output tcdo_pkg::tcdo_sizes_t      sizes_q,
  output logic                       irq_q,
  // Status pins from the outside world
  input  wire logic                  bus_comm_ok,
  input  wire logic                  bus_supply_ok,
  input  wire logic                  cfg_error,
  input  wire logic [1:0]            drv_overload,
  input  wire logic [1:0]            drv_short,
  input  wire logic [1:0]            drv_overheat,
  // Outputs to the field and the LEDs
  output logic [1:0]                 do_out_q,
  output logic                       run_led_q,
  output logic                       fault_indicator_led_q,
  output logic [1:0]                 ch_led_q
);
  import tcdo_pkg::*;

  // ------------------------------------------------------------------
  // Status pin synchronisers
  // ------------------------------------------------------------------

  logic [STAT_COUNT-1:0] stat_raw;
  logic [STAT_COUNT-1:0] s1_q;
  logic [STAT_COUNT-1:0] s2_q;
  logic [STAT_COUNT-1:0] s3_q;
  logic [STAT_COUNT-1:0] stat_q;
  logic [STAT_COUNT-1:0] stat_d;

  // Pack pins: comm, supply, cfg, then per-channel fault bits
  assign stat_raw = {drv_overheat, drv_short, drv_overload,
                     cfg_error, bus_supply_ok, bus_comm_ok};

  // Each pin takes a new level only once stages two and three agree,
  // so a single-cycle glitch after the first stage never reaches logic
  for (genvar i = 0; i < STAT_COUNT; i++) begin : g_sync
    always_comb begin
      stat_d[i] = stat_q[i];
      if (s2_q[i] == s3_q[i]) begin
        stat_d[i] = s3_q[i];
      end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        s1_q[i]   <= 1'b0;
        s2_q[i]   <= 1'b0;
        s3_q[i]   <= 1'b0;
        stat_q[i] <= 1'b0;
      end else begin
        s1_q[i]   <= stat_raw[i];
        s2_q[i]   <= s1_q[i];
        s3_q[i]   <= s2_q[i];
        stat_q[i] <= stat_d[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // Decoded status
  // ------------------------------------------------------------------

  logic       comm_ok;
  logic       supply_ok;
  logic       cfg_err;
  logic [1:0] ovl;
  logic [1:0] shrt;
  logic [1:0] ovht;
  logic       mod_err;

  // Unpack the filtered pins
  assign comm_ok   = stat_q[0];
  assign supply_ok = stat_q[1];
  assign cfg_err   = stat_q[2];
  assign ovl       = stat_q[4:3];
  assign shrt      = stat_q[6:5];
  assign ovht      = stat_q[8:7];

  // Any driver fault on any channel is one module error
  assign mod_err = |(ovl | shrt | ovht);                    // [RL11]

  // ------------------------------------------------------------------
  // Output image
  // ------------------------------------------------------------------

  logic [7:0] image_q;
  logic [7:0] image_d;
  logic       img_hit;
  logic       co_hit;
  logic       ecat_idx;
  logic       ecat_ch0;
  logic       ecat_ch1;
  logic [15:0] ecat_index;

  // Direct image access at offset zero
  assign img_hit = img_wr && (img_req.addr == OFS_IMAGE);   // [RL1]

  // CANopen object carries the whole byte
  assign co_hit = obj_wr && (obj_req.kind == OBJ_CANOPEN)
                  && (obj_req.index == CO_IDX_IMAGE)
                  && (obj_req.subidx == CO_SUB_IMAGE);      // [RL1]

  // EtherCAT index moves with the slot the module sits in
  assign ecat_index = ECAT_IDX_BASE + {8'h00, slot_num};    // [RL2]
  assign ecat_idx   = obj_wr && (obj_req.kind == OBJ_ETHERCAT)
                      && (obj_req.index == ecat_index);
  assign ecat_ch0   = ecat_idx && (obj_req.subidx == ECAT_SUB_CH0);
  assign ecat_ch1   = ecat_idx && (obj_req.subidx == ECAT_SUB_CH1);

  // Next image; a direct write in the same cycle wins over an object
  // write, since the process image is the cyclic path and must not lag
  always_comb begin
    image_d = image_q;
    if (img_hit) begin
      image_d = img_req.data & IMAGE_USED;                  // [RL11]
    end else if (co_hit) begin
      image_d = obj_req.data & IMAGE_USED;                  // [RL1]
    end else if (ecat_ch0) begin
      image_d[0] = obj_req.data[0];                         // [RL2]
    end else if (ecat_ch1) begin
      image_d[1] = obj_req.data[0];                         // [RL2]
    end
  end

  // Register the image
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      image_q <= IMAGE_RST;
    end else begin
      image_q <= image_d;
    end
  end

  // Handshakes answer in the cycle of the request
  assign img_ack = img_hit;
  assign obj_ack = co_hit || ecat_ch0 || ecat_ch1;
  assign obj_nak = obj_wr && !obj_ack;

  // ------------------------------------------------------------------
  // Refused services and constant reports
  // ------------------------------------------------------------------

  tcdo_sizes_t sizes_d;
  logic        irq_d;

  // Input reads, parameter writes and diagnostic reads are all refused
  assign svc_nak = svc_req.in_rd || svc_req.prm_wr
                   || svc_req.diag_rd;                      // [RL3] [RL10]

  // Size report; the interrupt line never rises
  always_comb begin
    sizes_d.in_bytes   = IN_BYTES;                          // [RL3]
    sizes_d.out_bytes  = OUT_BYTES;
    sizes_d.prm_bytes  = PRM_BYTES;                         // [RL10]
    sizes_d.diag_bytes = DIAG_BYTES;                        // [RL10]
    irq_d              = 1'b0;                              // [RL10]
  end

  // Register the reports
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sizes_q <= '0;
      irq_q   <= 1'b0;
    end else begin
      sizes_q <= sizes_d;
      irq_q   <= irq_d;
    end
  end

  // ------------------------------------------------------------------
  // LED mode selection
  // ------------------------------------------------------------------

  tcdo_led_mode_t mode_q;
  tcdo_led_mode_t mode_d;

  // Supply loss outranks all, since without it no LED can be driven;
  // a configuration error then outranks the driver fault display
  always_comb begin
    if (!supply_ok) begin
      mode_d = LED_DARK;                                    // [RL7]
    end else if (cfg_err) begin
      mode_d = LED_CFG;                                     // [RL8]
    end else if (comm_ok && !mod_err) begin
      mode_d = LED_RUN;                                     // [RL4]
    end else if (comm_ok) begin
      mode_d = LED_RUN_FLT;                                 // [RL5]
    end else if (mod_err) begin
      mode_d = LED_FLT_ONLY;                                // [RL6]
    end else begin
      mode_d = LED_DARK;
    end
  end

  // Register the mode
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= LED_DARK;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ------------------------------------------------------------------
  // Blinker and LED drive
  // ------------------------------------------------------------------

  logic       blink;
  logic       run_d;
  logic       flt_d;
  logic [1:0] ch_d;
  logic [1:0] do_d;

  // Blinks only while the configuration error mode holds
  tcdo_blink #(
    .HALF_CYC (BLINK_HALF)
  ) u_blink (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .en      (mode_q == LED_CFG),
    .blink_q (blink)
  );

  // LED levels per mode; run LED in config mode keeps comm state
  always_comb begin
    run_d = 1'b0;
    flt_d = 1'b0;
    case (mode_q)
      LED_DARK: begin
        run_d = 1'b0;                                       // [RL7]
        flt_d = 1'b0;
      end
      LED_RUN: begin
        run_d = 1'b1;                                       // [RL4]
        flt_d = 1'b0;
      end
      LED_RUN_FLT: begin
        run_d = 1'b1;                                       // [RL5]
        flt_d = 1'b1;
      end
      LED_FLT_ONLY: begin
        run_d = 1'b0;                                       // [RL6]
        flt_d = 1'b1;
      end
      LED_CFG: begin
        run_d = comm_ok;
        flt_d = blink;                                      // [RL8]
      end
      default: begin
        run_d = 1'b0;
        flt_d = 1'b0;
      end
    endcase
  end

  // Channels follow the image; their LEDs stay dark without supply
  always_comb begin
    do_d = image_q[CH_COUNT-1:0];                           // [RL1]
    ch_d = (mode_q == LED_DARK) ? 2'b00
                                : image_q[CH_COUNT-1:0];    // [RL9]
  end

  // Register all field and LED outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      do_out_q              <= 2'b00;
      run_led_q             <= 1'b0;
      fault_indicator_led_q <= 1'b0;
      ch_led_q              <= 2'b00;
    end else begin
      do_out_q              <= do_d;
      run_led_q             <= run_d;
      fault_indicator_led_q <= flt_d;
      ch_led_q              <= ch_d;
    end
  end

endmodule

//--- sim/tcdo_checker.sv
// Checker: port-level properties of the two-channel output port
`timescale 1ns/10ps
module tcdo_checker
  import tcdo_pkg::*;
#(
  parameter int BLINK_HALF = 8
) (
  // Clock and reset
  input wire logic                    mclk,
  input wire logic                    sys_rst,
  // Requests and answers
  input wire logic                    img_wr,
  input wire tcdo_pkg::tcdo_img_wr_t  img_req,
  input wire logic                    img_ack,
  input wire logic                    obj_wr,
  input wire tcdo_pkg::tcdo_obj_wr_t  obj_req,
  input wire logic [7:0]              slot_num,
  input wire logic                    obj_ack,
  input wire logic                    obj_nak,
  input wire tcdo_pkg::tcdo_svc_req_t svc_req,
  input wire logic                    svc_nak,
  input wire tcdo_pkg::tcdo_sizes_t   sizes_q,
  input wire logic                    irq_q,
  // Status pins and outputs
  input wire logic                    bus_comm_ok,
  input wire logic                    bus_supply_ok,
  input wire logic                    cfg_error,
  input wire logic [1:0]              drv_overload,
  input wire logic [1:0]              drv_short,
  input wire logic [1:0]              drv_overheat,
  input wire logic [1:0]              do_out_q,
  input wire logic                    run_led_q,
  input wire logic                    fault_indicator_led_q,
  input wire logic [1:0]              ch_led_q
);
  // --------------------------------------------------------------
  // Helper logic
  // --------------------------------------------------------------
  logic flt;
  logic prev_q;
  int   cnt_q;
  int   cnt_d;
  assign flt = |{drv_overload, drv_short, drv_overheat};

  // Cycles since the last blink edge; cleared outside blink mode
  always_comb begin
    cnt_d = cnt_q + 1;
    if (!cfg_error || !bus_supply_ok || fault_indicator_led_q != prev_q)
      cnt_d = 0;
  end

  // Register the counter
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q  <= 0;
      prev_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      prev_q <= fault_indicator_led_q;
    end
  end

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Pins settle through the synchroniser in 6 edges; 8 leaves slack
  sequence s_held(logic c);
    c [*8];
  endsequence
  sequence s_co;
    !img_wr && obj_wr && obj_req.kind == OBJ_CANOPEN
      && obj_req.index == 16'h5200 && obj_req.subidx == 8'h00;
  endsequence
  sequence s_ecat1;
    !img_wr && obj_wr && obj_req.kind == OBJ_ETHERCAT && obj_req.subidx
      == 8'h02 && obj_req.index == 16'h7000 + {8'h00, slot_num};
  endsequence

  property p_img_ack;
    img_ack == (img_wr && img_req.addr == 8'h00);
  endproperty
  property p_img_out;
    img_wr && img_req.addr == 8'h00 |->
      ##2 do_out_q == $past(img_req.data[1:0], 2);
  endproperty
  property p_obj_ans;
    (obj_ack || obj_nak) == obj_wr && !(obj_ack && obj_nak);
  endproperty
  property p_co;
    s_co |-> obj_ack ##2 do_out_q == $past(obj_req.data[1:0], 2);
  endproperty
  property p_ecat;
    s_ecat1 |-> obj_ack ##2 do_out_q[1] == $past(obj_req.data[0], 2);
  endproperty
  property p_svc;
    svc_nak == (|svc_req) && !irq_q;
  endproperty
  property p_sizes;
    !$past(sys_rst) |-> sizes_q == 32'h0001_0000;
  endproperty
  property p_run;
    s_held(bus_supply_ok && bus_comm_ok && !cfg_error && !flt)
      |-> run_led_q && !fault_indicator_led_q;
  endproperty
  property p_both;
    s_held(bus_supply_ok && bus_comm_ok && !cfg_error && flt)
      |-> run_led_q && fault_indicator_led_q;
  endproperty
  property p_flt_only;
    s_held(bus_supply_ok && !bus_comm_ok && !cfg_error && flt)
      |-> !run_led_q && fault_indicator_led_q;
  endproperty
  property p_dark;
    s_held(!bus_supply_ok)
      |-> !run_led_q && !fault_indicator_led_q && ch_led_q == 2'b00;
  endproperty
  property p_ch_led;
    s_held(bus_supply_ok && bus_comm_ok && !cfg_error)
      |-> ch_led_q == do_out_q;
  endproperty
  property p_blink;
    s_held(bus_supply_ok && cfg_error && $stable(bus_comm_ok))
      |-> cnt_q <= BLINK_HALF + 8 && run_led_q == bus_comm_ok;
  endproperty

  a_img_ack: assert property (p_img_ack)
    else $error("image ack mismatch");
  a_img_out: assert property (p_img_out)
    else $error("channel outputs do not follow image");
  a_obj_ans: assert property (p_obj_ans)
    else $error("object answer mismatch");
  a_co: assert property (p_co)
    else $error("CANopen write not applied");
  a_ecat: assert property (p_ecat)
    else $error("EtherCAT channel write not applied");
  a_svc: assert property (p_svc)
    else $error("service answer or interrupt wrong");
  a_sizes: assert property (p_sizes)
    else $error("data sizes wrong");
  a_run: assert property (p_run)
    else $error("healthy LED state wrong");
  a_both: assert property (p_both)
    else $error("fault with bus LED state wrong");
  a_flt_only: assert property (p_flt_only)
    else $error("fault without bus LED state wrong");
  a_dark: assert property (p_dark)
    else $error("supply loss LED state wrong");
  a_ch_led: assert property (p_ch_led)
    else $error("channel LEDs differ from outputs");
  a_blink: assert property (p_blink)
    else $error("fault LED blink too slow");
endmodule

bind tcdo_port tcdo_checker #(.BLINK_HALF(BLINK_HALF)) u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .img_wr(img_wr), .img_req(img_req),
  .img_ack(img_ack), .obj_wr(obj_wr), .obj_req(obj_req),
  .slot_num(slot_num), .obj_ack(obj_ack), .obj_nak(obj_nak),
  .svc_req(svc_req), .svc_nak(svc_nak), .sizes_q(sizes_q), .irq_q(irq_q),
  .bus_comm_ok(bus_comm_ok), .bus_supply_ok(bus_supply_ok),
  .cfg_error(cfg_error), .drv_overload(drv_overload),
  .drv_short(drv_short), .drv_overheat(drv_overheat),
  .do_out_q(do_out_q), .run_led_q(run_led_q),
  .fault_indicator_led_q(fault_indicator_led_q), .ch_led_q(ch_led_q)
);

//--- sim/tcdo_head.sv
// Head station model: writes the output image, objects and services
`timescale 1ns/10ps
module tcdo_head
  import tcdo_pkg::*;
(
  // Clock
  input  wire logic             mclk,
  // Requests towards the port
  output logic                  img_wr,
  output tcdo_img_wr_t          img_req,
  output logic                  obj_wr,
  output tcdo_obj_wr_t          obj_req,
  output tcdo_svc_req_t         svc_req,
  // Answers from the port
  input  wire logic             img_ack,
  input  wire logic             obj_ack,
  input  wire logic             obj_nak,
  input  wire logic             svc_nak
);
  // Idle bus at time zero
  initial begin
    img_wr  = 1'b0;
    img_req = '0;
    obj_wr  = 1'b0;
    obj_req = '0;
    svc_req = '0;
  end

  // One image write; released data is inverted so stale values show
  task automatic put_img(input logic [7:0] a, d, output logic ack);
    @(posedge mclk);
    img_wr  <= 1'b1;
    img_req <= '{addr: a, data: d};
    @(posedge mclk);
    ack = img_ack;
    img_wr  <= 1'b0;
    img_req <= ~img_req;
  endtask

  // One object write; answer is {ack, nak}
  task automatic put_obj(input tcdo_obj_kind_t k, input logic [15:0] i,
                         input logic [7:0] s, d, output logic [1:0] an);
    @(posedge mclk);
    obj_wr  <= 1'b1;
    obj_req <= '{kind: k, index: i, subidx: s, data: d};
    @(posedge mclk);
    an = {obj_ack, obj_nak};
    obj_wr  <= 1'b0;
    obj_req <= ~obj_req;
  endtask

  // One service request pulse
  task automatic put_svc(input tcdo_svc_req_t r, output logic nak);
    @(posedge mclk);
    svc_req <= r;
    @(posedge mclk);
    nak = svc_nak;
    svc_req <= '0;
  endtask
endmodule

//--- sim/tcdo_port_tb.sv
// Testbench: output image, object access, services and LED modes
`timescale 1ns/10ps
module tcdo_port_tb;
  import tcdo_pkg::*;
  localparam int HALF = 8;
  logic          mclk, sys_rst, img_wr, img_ack, obj_wr, obj_ack, obj_nak;
  logic          svc_nak, irq_q, run_led_q, fault_indicator_led_q;
  logic          bus_comm_ok, bus_supply_ok, cfg_error, ack, f;
  logic [1:0]    drv_overload, drv_short, drv_overheat, do_out_q, ch_led_q;
  logic [1:0]    an;
  logic [7:0]    slot_num;
  tcdo_img_wr_t  img_req;
  tcdo_obj_wr_t  obj_req;
  tcdo_svc_req_t svc_req;
  tcdo_sizes_t   sizes_q;
  int            errors, comparisons, n;
  logic [7:0]    imgs [5] = '{8'hFF, 8'h00, 8'hFE, 8'h01, 8'hFD};
  logic [15:0]   eix  [5] = '{16'h7003, 16'h7003, 16'h7003, 16'h7000,
                              16'h7003};
  logic [7:0]    esub [5] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h01};
  logic [1:0]    ean  [5] = '{2'b10, 2'b10, 2'b01, 2'b01, 2'b10};
  logic [1:0]    eout [5] = '{2'b11, 2'b01, 2'b01, 2'b01, 2'b00};
  logic [4:0]    led  [6] = '{5'b11010, 5'b11111, 5'b10101, 5'b10000,
                              5'b01100, 5'b00000};

  tcdo_port #(.BLINK_HALF(HALF)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .img_wr(img_wr), .img_req(img_req),
    .img_ack(img_ack), .obj_wr(obj_wr), .obj_req(obj_req),
    .slot_num(slot_num), .obj_ack(obj_ack), .obj_nak(obj_nak),
    .svc_req(svc_req), .svc_nak(svc_nak), .sizes_q(sizes_q),
    .irq_q(irq_q), .bus_comm_ok(bus_comm_ok),
    .bus_supply_ok(bus_supply_ok), .cfg_error(cfg_error),
    .drv_overload(drv_overload), .drv_short(drv_short),
    .drv_overheat(drv_overheat), .do_out_q(do_out_q),
    .run_led_q(run_led_q), .fault_indicator_led_q(fault_indicator_led_q),
    .ch_led_q(ch_led_q));
  tcdo_head head (
    .mclk(mclk), .img_wr(img_wr), .img_req(img_req), .obj_wr(obj_wr),
    .obj_req(obj_req), .svc_req(svc_req), .img_ack(img_ack),
    .obj_ack(obj_ack), .obj_nak(obj_nak), .svc_nak(svc_nak));

  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Two edges from taking to outputs, then let updates land
  task automatic settle(input int c = 2);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    wrap_up();
  end

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    {sys_rst, errors, comparisons, slot_num} = {1'b1, 64'd0, 8'h03};
    {bus_comm_ok, bus_supply_ok, cfg_error} = 3'b000;
    {drv_overload, drv_short, drv_overheat} = 6'b0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    settle(1);
    chk("sizes", 32'h0001_0000, sizes_q);
    chk("irq", 1'b0, irq_q);
    chk("out", 2'b00, do_out_q);
    @(posedge mclk);
    {bus_supply_ok, bus_comm_ok} <= 2'b11;
    settle(10);
    $display("test reset done");
    // Image writes, reserved bits set and cleared
    foreach (imgs[i]) begin
      head.put_img(8'h00, imgs[i], ack);
      chk("img_ack", 1'b1, ack);
      settle();
      chk("out", imgs[i][1:0], do_out_q);
      chk("ch_led", imgs[i][1:0], ch_led_q);
    end
    head.put_img(8'h01, 8'h02, ack);
    chk("img_ack bad", 1'b0, ack);
    settle();
    chk("out kept", 2'b01, do_out_q);
    $display("test image done");
    // CANopen whole byte, then a wrong index
    head.put_obj(OBJ_CANOPEN, 16'h5200, 8'h00, 8'hFE, an);
    chk("co ans", 2'b10, an);
    head.put_obj(OBJ_CANOPEN, 16'h5201, 8'h00, 8'h01, an);
    chk("co bad", 2'b01, an);
    settle();
    chk("co out", 2'b10, do_out_q);
    // EtherCAT per-bit subindices at slot 3, bad subindex and slot
    foreach (eix[i]) begin
      head.put_obj(OBJ_ETHERCAT, eix[i], esub[i], {7'h7F, eout[i][i == 1]},
                   an);
      chk("ecat ans", ean[i], an);
      settle();
      chk("ecat out", eout[i], do_out_q);
    end
    $display("test objects done");
    for (int i = 0; i < 3; i++) begin
      head.put_svc(tcdo_svc_req_t'(3'b001 << i), ack);
      chk("svc_nak", 1'b1, ack);
    end
    $display("test services done");
    head.put_img(8'h00, 8'h02, ack);
    // LED modes: {supply, comm, fault} -> {run, fault LED}
    foreach (led[i]) begin
      @(posedge mclk);
      {bus_supply_ok, bus_comm_ok} <= led[i][4:3];
      {drv_overload, drv_short, drv_overheat} <= led[i][2] ? 6'd1 << i : 6'd0;
      settle(10);
      chk("run", led[i][1], run_led_q);
      chk("fault", led[i][0], fault_indicator_led_q);
      chk("ch_led", i < 3 ? 2'b10 : 2'b00, ch_led_q);
    end
    $display("test leds done");
    // Configuration error: blink at HALF cycles per phase
    @(posedge mclk);
    {bus_supply_ok, bus_comm_ok, cfg_error} <= 3'b111;
    settle(10);
    for (int k = 0; k < 2; k++) begin
      f = fault_indicator_led_q;
      n = 0;
      while (fault_indicator_led_q === f && n < 100) begin
        settle(1);
        n++;
      end
    end
    chk("blink", HALF, n);
    chk("run blink", 1'b1, run_led_q);
    @(posedge mclk);
    bus_supply_ok <= 1'b0;
    settle(10);
    $display("test blink done");
    // Second reset clears the outputs
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    settle(3);
    chk("out rst", 2'b00, do_out_q);
    $display("test rereset done");
    wrap_up();
  end
endmodule
